// ---- otpa_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Drive whole byte on data pins.
// - Program mode: supply up, strobe low.
// - One 100 us low program pulse.
// - Retry mismatches, at most 25 pulses; here a mismatch that needs a zero to return to one fails at once.
// - Program every address in turn; here each command programs one byte and the caller walks the array.
// - Ganged: select pulse programs one device.
// - Verify: select, enable low, strobe high.
// - Identifier mode: high voltage on line.
// - Other address lines low for identifier.
// - Data valid output-gate delay after enable.
// - Decode select; enable shares read strobe.
module otpa_ctrl
   import otpa_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC
) (
   input  wire logic          sys_clk_i,
   input  wire logic          rst_i,
   input  wire logic          cmd_valid_i,
   output logic               cmd_ready_o,
   input  wire logic [1:0]    cmd_op_i,
   input  wire logic [16:0]   cmd_addr_i,
   input  wire logic [7:0]    cmd_wdata_i,
   input  wire logic          cmd_gang_i,
   output logic               done_o,
   output logic [7:0]         rdata_o,
   output logic               fail_o,
   output logic               parity_ok_o,
   output logic [4:0]         pulses_o,
   output logic [16:0]        mem_addr_o,
   output logic               select_n_o,
   output logic               out_en_n_o,
   output logic               program_strobe_n_o,
   output logic               vpp_en_o,
   output logic               id_hv_en_o,
   output logic [7:0]         mem_data_o,
   output logic               mem_data_oe_o,
   input  wire logic [7:0]    mem_data_i
);
   otpa_state_t       state_q, state_d;   // Sequencer state.
   logic [CNT_W-1:0]  cnt_q, cnt_d;       // Down counter for timed waits.
   otpa_op_t          op_q, op_d;         // Command in progress.
   logic              gang_q, gang_d;     // Pulse on select instead of strobe.
   logic [16:0]       addr_q, addr_d;     // Address on the pins.
   logic [7:0]        wdata_q, wdata_d;   // Byte being programmed.
   logic [7:0]        rdata_q, rdata_d;   // Last byte read back.
   logic              fail_q, fail_d;     // Program gave up.
   logic              par_q, par_d;       // Odd parity of last read.
   logic [4:0]        pulses_q, pulses_d; // Pulses spent on this byte.
   // Pin drivers, registered so the memory never sees decode glitches.
   logic sel_n_q, sel_n_d, oe_n_q, oe_n_d, stb_n_q, stb_n_d;
   logic vpp_q, vpp_d, hv_q, hv_d, doe_q, doe_d;
   logic [7:0]        rbyte;              // Synchronised data pins.

   // Waits are loaded as length minus one so a state lasts exactly that long.
   function automatic logic [CNT_W-1:0] wait_of(input int cycles);
      return CNT_W'(cycles - 1);
   endfunction

   otpa_sync #(.W(DATA_W)) u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .d_i       (mem_data_i),
      .q_o       (rbyte)
   );

   // Sequencer: reads, identifier reads and the pulse-and-verify loop.
   always_comb begin
      state_d  = state_q;
      cnt_d    = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
      op_d     = op_q;
      gang_d   = gang_q;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      rdata_d  = rdata_q;
      fail_d   = fail_q;
      par_d    = par_q;
      pulses_d = pulses_q;
      case (state_q)
         S_IDLE: begin
            if (cmd_valid_i) begin
               gang_d   = cmd_gang_i;
               wdata_d  = cmd_wdata_i;
               fail_d   = 1'b0;
               pulses_d = 5'h00;
               addr_d   = cmd_addr_i;
               if (cmd_op_i == OTPA_OP_PROG) begin
                  // Each command programs one byte; the caller walks the array.
                  op_d    = OTPA_OP_PROG;
                  state_d = S_SETUP;
                  cnt_d   = wait_of(DF_CYC + AS_CYC);
               end else if (cmd_op_i == OTPA_OP_ID) begin
                  // Only bit zero may vary; the rest are held low.
                  op_d    = OTPA_OP_ID;
                  addr_d  = {16'h0000, cmd_addr_i[0]};
                  state_d = S_READ;
                  cnt_d   = wait_of(RD_WAIT);
               end else begin
                  // Unknown codes are served as plain reads.
                  op_d    = OTPA_OP_READ;
                  state_d = S_READ;
                  cnt_d   = wait_of(RD_WAIT);
               end
            end
         end
         S_SETUP: begin
            // Old outputs float first, then address and data settle.
            if (cnt_q == '0) begin
               state_d  = S_PULSE;
               cnt_d    = wait_of(PULSE_CYCLES);
               pulses_d = pulses_q + 5'h01;
            end
         end
         S_PULSE: begin
            if (cnt_q == '0) begin
               state_d = S_HOLD;
               cnt_d   = wait_of(DH_CYC);
            end
         end
         S_HOLD: begin
            if (cnt_q == '0) begin
               state_d = S_VERIFY;
               cnt_d   = wait_of(RD_WAIT);
            end
         end
         S_VERIFY: begin
            // Access time plus synchroniser before the byte is trusted.
            if (cnt_q == '0) begin
               state_d = S_CHECK;
            end
         end
         S_CHECK: begin
            rdata_d = rbyte;
            par_d   = ^rbyte;
            if (rbyte == wdata_q) begin
               state_d = S_DONE;
            end else if ((wdata_q & ~rbyte) != 8'h00) begin
               // A stored zero can never return to one, so retrying is futile.
               fail_d  = 1'b1;
               state_d = S_DONE;
            end else if (pulses_q >= 5'(MAX_PULSES)) begin
               fail_d  = 1'b1;
               state_d = S_DONE;
            end else begin
               state_d = S_SETUP;
               cnt_d   = wait_of(DF_CYC + AS_CYC);
            end
         end
         S_READ: begin
            if (cnt_q == '0) begin
               rdata_d = rbyte;
               // Identifier bytes should show odd parity.
               par_d   = ^rbyte;
               state_d = S_DONE;
            end
         end
         S_DONE: begin
            state_d = S_IDLE;
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   // Pin levels follow the next state, so pins and state change together.
   always_comb begin
      sel_n_d = 1'b1;
      oe_n_d  = 1'b1;
      stb_n_d = 1'b1;
      vpp_d   = 1'b0;
      hv_d    = 1'b0;
      doe_d   = 1'b0;
      case (state_d)
         S_SETUP: begin
            // Ganged parts wait deselected with the strobe already low.
            sel_n_d = gang_d;
            stb_n_d = ~gang_d;
            vpp_d   = 1'b1;
            // Data is driven only after the outputs have floated.
            doe_d   = (cnt_d < CNT_W'(AS_CYC));
         end
         S_PULSE: begin
            // Program mode: supply up, output enable high.
            sel_n_d = 1'b0;
            stb_n_d = 1'b0;
            vpp_d   = 1'b1;
            doe_d   = 1'b1;
         end
         S_HOLD: begin
            sel_n_d = gang_d;
            stb_n_d = ~gang_d;
            vpp_d   = 1'b1;
            doe_d   = 1'b1;
         end
         S_VERIFY, S_CHECK: begin
            sel_n_d = 1'b0;
            oe_n_d  = 1'b0;
            vpp_d   = 1'b1;
         end
         S_READ: begin
            // Both controls low together; select acts as the read strobe.
            sel_n_d = 1'b0;
            oe_n_d  = 1'b0;
            hv_d    = (op_d == OTPA_OP_ID);
         end
         default: begin
            sel_n_d = 1'b1;
         end
      endcase
   end

   // Registers only.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q  <= S_IDLE;
         cnt_q    <= '0;
         op_q     <= OTPA_OP_READ;
         gang_q   <= 1'b0;
         addr_q   <= '0;
         wdata_q  <= ERASED_BYTE;
         rdata_q  <= ERASED_BYTE;
         fail_q   <= 1'b0;
         par_q    <= 1'b0;
         pulses_q <= 5'h00;
         sel_n_q  <= 1'b1;
         oe_n_q   <= 1'b1;
         stb_n_q  <= 1'b1;
         vpp_q    <= 1'b0;
         hv_q     <= 1'b0;
         doe_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         op_q     <= op_d;
         gang_q   <= gang_d;
         addr_q   <= addr_d;
         wdata_q  <= wdata_d;
         rdata_q  <= rdata_d;
         fail_q   <= fail_d;
         par_q    <= par_d;
         pulses_q <= pulses_d;
         sel_n_q  <= sel_n_d;
         oe_n_q   <= oe_n_d;
         stb_n_q  <= stb_n_d;
         vpp_q    <= vpp_d;
         hv_q     <= hv_d;
         doe_q    <= doe_d;
      end
   end

   assign cmd_ready_o        = (state_q == S_IDLE);
   assign done_o             = (state_q == S_DONE);
   assign rdata_o            = rdata_q;
   assign fail_o             = fail_q;
   assign parity_ok_o        = par_q;
   assign pulses_o           = pulses_q;
   assign mem_addr_o         = addr_q;
   assign select_n_o         = sel_n_q;
   assign out_en_n_o         = oe_n_q;
   assign program_strobe_n_o = stb_n_q;
   assign vpp_en_o           = vpp_q;
   assign id_hv_en_o         = hv_q;
   assign mem_data_o         = wdata_q;
   assign mem_data_oe_o      = doe_q;

   // Length of the current strobe-low stretch, for checking only.
   logic [CNT_W-1:0] low_q;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || program_strobe_n_o) begin
         low_q <= '0;
      end else begin
         low_q <= low_q + 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   property p_drive;
      mem_data_oe_o |-> out_en_n_o && vpp_en_o;
   endproperty
   a_drive: assert property (p_drive) else $error("data driven outside program mode");
   property p_pmode;
      !program_strobe_n_o |-> vpp_en_o && out_en_n_o;
   endproperty
   a_pmode: assert property (p_pmode) else $error("strobe low outside program mode");
   property p_pulse;
      disable iff (rst_i || gang_q)
      $rose(program_strobe_n_o) |-> low_q == CNT_W'(PULSE_CYCLES);
   endproperty
   a_pulse: assert property (p_pulse) else $error("program pulse width wrong");
   property p_count;
      $rose(state_q == S_PULSE) |-> pulses_q >= 5'h01 && pulses_q <= 5'(MAX_PULSES);
   endproperty
   a_count: assert property (p_count) else $error("pulse count out of range");
   property p_gang;
      gang_q && state_q == S_SETUP |-> select_n_o ##0 !program_strobe_n_o;
   endproperty
   a_gang: assert property (p_gang) else $error("ganged setup not inhibited");
   property p_verify;
      state_q == S_CHECK |-> !select_n_o && !out_en_n_o && program_strobe_n_o && vpp_en_o;
   endproperty
   a_verify: assert property (p_verify) else $error("verify pin levels wrong");
   property p_ident;
      id_hv_en_o |-> !select_n_o && !out_en_n_o && !vpp_en_o;
   endproperty
   a_ident: assert property (p_ident) else $error("identifier mode pins wrong");
   property p_idaddr;
      id_hv_en_o |-> (mem_addr_o & ~ID_ADDR_MASK) == 17'h00000 && !mem_addr_o[9];
   endproperty
   a_idaddr: assert property (p_idaddr) else $error("identifier address not low");

   property p_access;
      $rose(state_q == S_READ) |-> cnt_q == CNT_W'(RD_WAIT - 1) ##1 !out_en_n_o;
   endproperty
   a_access: assert property (p_access) else $error("read wait wrong");

   property p_nozero;
      state_q == S_CHECK && (wdata_q & ~rbyte) != 8'h00 |=> state_q == S_DONE && fail_q;
   endproperty
   a_nozero: assert property (p_nozero) else $error("impossible byte not failed");
endmodule

`default_nettype wire

// ---- otpa_pkg.sv ----
`default_nettype none

package otpa_pkg;

   // System clock rate in MHz; every cycle count below except SYNC_LAT derives from it.
   localparam int CLK_MHZ     = 100;
   // Counter width for all timed waits.
   localparam int CNT_W       = 16;

   // Slowest speed grade, so any part is covered.
   localparam int T_ACC_NS    = 250;  // Address access time.
   localparam int T_DF_NS     = 70;   // Output float after output enable rises.
   localparam int T_AS_NS     = 2000; // Address and data setup before a pulse.
   localparam int T_DH_NS     = 2000; // Data hold after a pulse.
   localparam int T_PULSE_US  = 100;  // Program pulse width.

   // Least times round up to whole cycles.
   localparam int ACC_CYC     = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int DF_CYC      = (T_DF_NS * CLK_MHZ + 999) / 1000;
   localparam int AS_CYC      = (T_AS_NS * CLK_MHZ + 999) / 1000;
   localparam int DH_CYC      = (T_DH_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_CYC   = T_PULSE_US * CLK_MHZ;
   // Read wait beyond the access time. Three stages and the filter register
   // take four edges. One more edge is needed because the access time ends
   // on a clock edge, where the first stage may still take the old level.
   localparam int SYNC_LAT    = 5;
   localparam int RD_WAIT     = ACC_CYC + SYNC_LAT;

   localparam int MAX_PULSES  = 25;
   localparam int ADDR_W      = 17;
   localparam int DATA_W      = 8;
   localparam logic [7:0]  ERASED_BYTE  = 8'hff;
   // Address bits allowed high during identifier readout.
   localparam logic [16:0] ID_ADDR_MASK = 17'h00201;

   // User command codes.
   typedef enum logic [1:0] {
      OTPA_OP_READ = 2'h0,
      OTPA_OP_PROG = 2'h1,
      OTPA_OP_ID   = 2'h2
   } otpa_op_t;

   // Sequencer states, Gray coded along the program path.
   typedef enum logic [2:0] {
      S_IDLE   = 3'h0,
      S_SETUP  = 3'h1,
      S_PULSE  = 3'h3,
      S_HOLD   = 3'h2,
      S_VERIFY = 3'h6,
      S_CHECK  = 3'h7,
      S_DONE   = 3'h5,
      S_READ   = 3'h4
   } otpa_state_t;

endpackage

`default_nettype wire

// ---- otpa_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Brings the memory data pins into the clock domain. The value moves on
// only when the second and third stages agree, which filters a single
// metastable sample at the cost of one extra cycle.
module otpa_sync #(
   parameter int W = 8
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1_q;  // First stage, read only by the second.
   logic [W-1:0] s2_q;  // Second stage.
   logic [W-1:0] s3_q;  // Third stage.
   logic [W-1:0] q_q;   // Filtered output.
   logic [W-1:0] q_d;

   // Accept a bit once two settled stages agree on it.
   always_comb begin
      q_d = q_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            q_d[i] = s3_q[i];
         end
      end
   end

   // Registers only.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         q_q  <= '1;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_q  <= q_d;
      end
   end

   assign q_o = q_q;
endmodule

`default_nettype wire

// ---- otpa_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behavioural model of the one-time-programmable memory on the far side of the controller.
// It has no clock. Its pins follow the control levels, with the access delay applied to the data.
module otpa_dev_model
   import otpa_pkg::*;
#(
   parameter int         PULSE_NS   = 100000, // Shortest program pulse that is accepted.
   parameter logic [7:0] MAKER_CODE = 8'h8a,  // Arbitrary value with odd parity.
   parameter logic [7:0] TYPE_CODE  = 8'h07   // Arbitrary value with odd parity.
) (
   input  wire logic [16:0] mem_addr_i,
   input  wire logic        select_n_i,
   input  wire logic        out_en_n_i,
   input  wire logic        program_strobe_n_i,
   input  wire logic        vpp_en_i,
   input  wire logic        id_hv_en_i,
   input  wire logic [7:0]  host_data_i,
   input  wire logic        host_data_oe_i,
   input  wire logic [5:0]  extra_pulses_i,
   output logic      [7:0]  pin_data_o
);
   logic [7:0]  mem [int];     // Programmed bytes only; missing entries are blank.
   int          gen = 0;       // Bumped on every write so the read path re-evaluates.
   int          miss = 0;      // Pulses swallowed so far by a slow cell.
   realtime     t0 = 0;        // Start time of the current program pulse.
   logic [7:0]  rd_now;        // Undelayed array or identifier value.
   logic [7:0]  last_q = 8'h00; // Last level seen on the pins.
   wire logic [7:0] rd_dly;    // Value after the access delay.
   wire logic   drive_w;       // The device drives its data pins.
   wire logic   prog_w;        // Program pulse is active.

   // Blank cells read as ones.
   function automatic logic [7:0] rd(input logic [16:0] a);
      return mem.exists(a) ? mem[a] : ERASED_BYTE;
   endfunction

   // Outputs only with both enables low; select high floats them whatever the rest.
   assign drive_w = !select_n_i && !out_en_n_i;
   // Program mode needs the supply, selection, a low strobe and output enable high.
   assign prog_w = vpp_en_i && !select_n_i && !program_strobe_n_i && out_en_n_i;

   // Array or identifier value; stray address bits spoil the identifier.
   always @(mem_addr_i or id_hv_en_i or gen) begin
      if (id_hv_en_i) begin
         if ((mem_addr_i & ~ID_ADDR_MASK) != 17'h00000) begin
            rd_now = 8'h00;
         end else begin
            rd_now = mem_addr_i[0] ? TYPE_CODE : MAKER_CODE;
         end
      end else begin
         rd_now = rd(mem_addr_i);
      end
   end

   // The data follows the address only after the access time.
   assign #(T_ACC_NS) rd_dly = rd_now;

   // A released bus shows the inverse of its last level, so stale data cannot pass.
   assign pin_data_o = drive_w ? rd_dly : (host_data_oe_i ? host_data_i : ~last_q);

   // Track the last driven level.
   always @(pin_data_o) begin
      if (drive_w || host_data_oe_i) begin
         last_q = pin_data_o;
      end
   end

   // Note when a pulse starts.
   always @(posedge prog_w) begin
      t0 = $realtime;
   end

   // A full-length pulse clears bits that the host drives low; undriven pins write zeros.
   // A slow cell ignores the given number of pulses first.
   always @(negedge prog_w) begin
      if ($realtime - t0 >= PULSE_NS) begin
         if (miss < int'(extra_pulses_i)) begin
            miss++;
         end else begin
            mem[mem_addr_i] = rd(mem_addr_i) & (host_data_oe_i ? host_data_i : 8'h00);
            miss = 0;
            gen++;
         end
      end
   end
endmodule

`default_nettype wire

// ---- otpa_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench: each scenario after the reset check issues commands and judges the results.
module testbench;
   import otpa_pkg::*;

   localparam int         PULSE_T = 20;     // Short pulse keeps the run brief.
   localparam logic [7:0] MAKER   = 8'h8a;  // Arbitrary value with odd parity.
   localparam logic [7:0] DTYPE   = 8'h07;  // Arbitrary value with odd parity.

   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        cmd_valid = 1'b0;
   logic [1:0]  cmd_op = 2'h0;
   logic [16:0] cmd_addr = 17'h00000;
   logic [7:0]  cmd_wdata = 8'h00;
   logic        cmd_gang = 1'b0;
   logic [5:0]  extra = 6'h00;
   wire logic   ready, done, fail, parity_ok, sel_n, oe_n, strobe_n, vpp, hv, mdoe;
   wire logic [7:0]  rdata, mdo, mdi;
   wire logic [4:0]  pulses;
   wire logic [16:0] maddr;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cyc;      // Cycles from acceptance to completion.
   int          low_cyc;  // Cycles with strobe and select both low during a command.
   int          bad_pin;  // Cycles with strobe and select both low but pins wrong.

   // Free-running clock.
   always #5 sys_clk = ~sys_clk;

   otpa_ctrl #(.PULSE_CYCLES(PULSE_T)) dut_u (
      .sys_clk_i(sys_clk), .rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_ready_o(ready),
      .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
      .cmd_gang_i(cmd_gang), .done_o(done), .rdata_o(rdata), .fail_o(fail),
      .parity_ok_o(parity_ok), .pulses_o(pulses), .mem_addr_o(maddr),
      .select_n_o(sel_n), .out_en_n_o(oe_n), .program_strobe_n_o(strobe_n),
      .vpp_en_o(vpp), .id_hv_en_o(hv), .mem_data_o(mdo), .mem_data_oe_o(mdoe),
      .mem_data_i(mdi));

   otpa_dev_model #(.PULSE_NS(PULSE_T * 10), .MAKER_CODE(MAKER), .TYPE_CODE(DTYPE)) dev_u (
      .mem_addr_i(maddr), .select_n_i(sel_n), .out_en_n_i(oe_n),
      .program_strobe_n_i(strobe_n), .vpp_en_i(vpp), .id_hv_en_i(hv),
      .host_data_i(mdo), .host_data_oe_i(mdoe), .extra_pulses_i(extra), .pin_data_o(mdi));

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One comparison; a mismatch is reported at once.
   task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t ns: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // Issues one command and waits, bounded, for completion; inputs move at the falling edge.
   task automatic do_cmd(input logic [1:0] op, input logic [16:0] a, input logic [7:0] wd,
                         input logic g);
      int n;
      n = 0;
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = wd;
      cmd_gang = g;
      while (ready !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      cyc = 0;
      low_cyc = 0;
      bad_pin = 0;
      while (done !== 1'b1 && cyc < 20000) begin
         @(negedge sys_clk);
         cyc++;
         if ((g ? sel_n : strobe_n) === 1'b0 && (g ? strobe_n : sel_n) === 1'b0) begin
            low_cyc++;
            if (vpp !== 1'b1 || mdoe !== 1'b1 || maddr !== a || mdo !== wd) bad_pin++;
         end
      end
      chk({16'h0000, done}, 17'h00001, "command completion");
   endtask

   // Values right after reset.
   task automatic t_reset();
      chk({16'h0000, ready}, 17'h00001, "ready after reset");
      chk({12'h000, sel_n, oe_n, strobe_n, vpp, hv}, 17'h0001c, "pins after reset");
      chk({9'h000, rdata}, 17'h000ff, "rdata after reset");
   endtask

   // Blank read with its timing, then the spare code as a read.
   task automatic t_blank_read();
      do_cmd(2'h0, 17'h1abcd, 8'h00, 1'b0);
      chk(17'(cyc), 17'(RD_WAIT), "read latency");
      chk({9'h000, rdata}, 17'h000ff, "blank byte");
      chk({16'h0000, parity_ok}, 17'h00000, "blank parity");
      chk({16'h0000, ready}, 17'h00000, "ready in done cycle");
      @(negedge sys_clk);
      chk({16'h0000, ready}, 17'h00001, "ready after done");
      do_cmd(2'h3, 17'h00010, 8'h00, 1'b0);
      chk({9'h000, rdata}, 17'h000ff, "spare code reads");
   endtask

   // Programs a byte, then reads and checks it.
   task automatic prog_and_read(input logic [16:0] a, input logic [7:0] wd, input logic g,
                                input logic [4:0] exp_p);
      do_cmd(2'h1, a, wd, g);
      chk({16'h0000, fail}, 17'h00000, "program fail flag");
      chk({12'h000, pulses}, {12'h000, exp_p}, "pulse count");
      chk(17'(low_cyc), 17'(PULSE_T * exp_p), "pulse length");
      chk(17'(bad_pin), 17'h00000, "pins during pulse");
      extra = 6'h00;
      do_cmd(2'h0, a, 8'h00, 1'b0);
      chk({9'h000, rdata}, {9'h000, wd}, "read back");
   endtask

   // Slow cell that never takes, then bits that cannot go back to one.
   task automatic t_give_up();
      extra = 6'h28;
      do_cmd(2'h1, 17'h00004, 8'h00, 1'b0);
      chk({16'h0000, fail}, 17'h00001, "gives up");
      chk({12'h000, pulses}, 17'(MAX_PULSES), "pulse limit");
      extra = 6'h00;
      do_cmd(2'h1, 17'h1abcd, 8'ha5, 1'b0);
      chk({16'h0000, fail}, 17'h00001, "zero to one refused");
   endtask

   // Identifier bytes with stray address bits that must be cleared.
   task automatic t_ident();
      do_cmd(2'h2, 17'h1fffe, 8'h00, 1'b0);
      chk({9'h000, rdata}, {9'h000, MAKER}, "maker code");
      chk({16'h0000, parity_ok}, 17'h00001, "maker parity");
      do_cmd(2'h2, 17'h00201, 8'h00, 1'b0);
      chk({9'h000, rdata}, {9'h000, DTYPE}, "type code");
      chk({16'h0000, parity_ok}, 17'h00001, "type parity");
   endtask

   // Main sequence.
   initial begin
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      t_reset();
      t_blank_read();
      prog_and_read(17'h1abcd, 8'h5a, 1'b0, 5'h01);
      extra = 6'h02;
      prog_and_read(17'h00003, 8'h3c, 1'b0, 5'h03);
      prog_and_read(17'h00005, 8'h81, 1'b1, 5'h01);
      t_give_up();
      t_ident();
      print_verdict();
   end

   // Watchdog, sized well above the longest expected run.
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      $display("Error at %0t ns: watchdog expired", $time);
      print_verdict();
   end
endmodule

`default_nettype wire
